// ### rtl/pcr_pkg.sv
// constants for the pll setup and system event flag block
package pcr_pkg;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses on the axi4-lite port
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFS_PLL     = 8'h04;
  localparam logic [7:0]  OFS_FLAGS   = 8'h08;
  localparam logic [7:0]  OFS_MASK    = 8'h10;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // pll_setup layout
  localparam logic [31:0] PLL_RST     = 32'h0003c019;
  localparam logic [31:0] PLL_RW_MASK = 32'h000fffff;
  localparam int          PLL_EN_BIT  = 19;
  localparam int          POST_MSB    = 18;
  localparam int          POST_LSB    = 16;
  localparam int          FB_MSB      = 15;
  localparam int          FB_LSB      = 8;
  localparam int          PRE_MSB     = 7;
  localparam int          PRE_LSB     = 0;
  // reset dividers give this output for this reference
  localparam int          REF_MHZ     = 25;
  localparam int          OUT_MHZ     = 48;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // system_event_flags layout
  localparam int          FLAG_W      = 6;
  localparam logic [5:0]  FLAG_RST    = 6'h08;
  localparam int          FLG_LOCK    = 0;
  localparam int          FLG_LOST    = 1;
  localparam int          FLG_WDG     = 2;
  localparam int          FLG_LVD     = 3;
  localparam int          FLG_ACK     = 4;
  localparam int          FLG_ERR     = 5;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // event_mask_reg layout
  localparam int          MASK_W      = 5;
  localparam logic [4:0]  MASK_RST    = 5'h1f;
  localparam int          MSK_LOCK    = 0;
  localparam int          MSK_LOST    = 1;
  localparam int          MSK_ACK     = 2;
  localparam int          MSK_ERR     = 3;
  localparam int          MSK_LVD     = 4;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // bus answers
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage : pcr_pkg

// ### rtl/pcr_pll_status.sv
// pll setup, system event flags, event mask and irq behind an axi4-lite slave
`timescale 1ns/1ps
module pcr_pll_status
  import pcr_pkg::*;
(
  input  wire logic                      REF_CLK_I,      // 200 mhz clock
  input  wire logic                      RST_B_I,        // power-on reset, active low
  input  wire logic                      SYS_RESET_I,    // system reset active, high
  input  wire logic                      LVD_CAUSE_I,    // reset cause low voltage
  input  wire logic                      WDG_CAUSE_I,    // reset cause watchdog
  input  wire logic                      PLL_LOCK_I,     // pll lock indication
  input  wire logic                      MEM_WR_ERR_I,   // invalid write pulse
  input  wire logic                      CACHE_ACK_I,    // cache enable ack pulse
  input  wire logic [pcr_pkg::ADDR_W-1:0] AWADDR_I,      // write address
  input  wire logic                      AWVALID_I,      // write address valid
  output logic                           AWREADY_O,      // write address ready
  input  wire logic [31:0]               WDATA_I,        // write data
  input  wire logic [3:0]                WSTRB_I,        // write byte strobes
  input  wire logic                      WVALID_I,       // write data valid
  output logic                           WREADY_O,       // write data ready
  output logic [1:0]                     BRESP_O,        // write response
  output logic                           BVALID_O,       // write response valid
  input  wire logic                      BREADY_I,       // write response ready
  input  wire logic [pcr_pkg::ADDR_W-1:0] ARADDR_I,      // read address
  input  wire logic                      ARVALID_I,      // read address valid
  output logic                           ARREADY_O,      // read address ready
  output logic [31:0]                    RDATA_O,        // read data
  output logic [1:0]                     RRESP_O,        // read response
  output logic                           RVALID_O,       // read data valid
  input  wire logic                      RREADY_I,       // read data ready
  output logic                           PLL_EN_O,       // pll enable
  output logic [2:0]                     PLL_POST_DIV_O, // post_divide
  output logic [7:0]                     PLL_FB_DIV_O,   // feedback_divide
  output logic [7:0]                     PLL_PRE_DIV_O,  // pre_divide
  output logic                           IRQ_O           // to vectored_irq_controller
);

  import pcr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // declarations
  logic                awready_q;
  logic                wready_q;
  logic                aw_got_q;
  logic                w_got_q;
  logic [ADDR_W-1:0]   awaddr_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                arready_q;
  logic                rvalid_q;
  logic [31:0]         rdata_q;
  logic [1:0]          rresp_q;
  logic [31:0]         pll_q;
  logic [FLAG_W-1:0]   flags_q;
  logic [FLAG_W-1:0]   flags_d;
  logic [MASK_W-1:0]   mask_q;
  logic [MASK_W-1:0]   pend;
  logic                lock_prev_q;
  logic                sys_rst_prev_q;
  logic                irq_q;
  logic                aw_hs;
  logic                w_hs;
  logic                ar_hs;
  logic                do_write;
  logic                wr_pll;
  logic                wr_flags;
  logic                wr_mask;
  logic                leave_rst;
  logic [FLAG_W-1:0]   set_vec;
  logic [FLAG_W-1:0]   clr_vec;
  logic [31:0]         rd_mux;
  logic [1:0]          rd_resp;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order, then one response
  assign aw_hs    = AWVALID_I & awready_q;
  assign w_hs     = WVALID_I & wready_q;
  assign do_write = aw_got_q & w_got_q & ~bvalid_q;
  assign wr_pll   = do_write & (awaddr_q == OFS_PLL);
  assign wr_flags = do_write & (awaddr_q == OFS_FLAGS);
  assign wr_mask  = do_write & (awaddr_q == OFS_MASK);

  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      aw_got_q  <= 1'b0;
      awready_q <= 1'b1;
      awaddr_q  <= '0;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_got_q  <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q  <= AWADDR_I;
      end
      else if (do_write)
      begin
        aw_got_q  <= 1'b0;
        awready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      w_got_q  <= 1'b0;
      wready_q <= 1'b1;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end
    else
    begin
      if (w_hs)
      begin
        w_got_q  <= 1'b1;
        wready_q <= 1'b0;
        wdata_q  <= WDATA_I;
        wstrb_q  <= WSTRB_I;
      end
      else if (do_write)
      begin
        w_got_q  <= 1'b0;
        wready_q <= 1'b1;
      end
    end
  end

  // unmapped offsets still get a response so the master never hangs
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end
    else
    begin
      if (do_write)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= (wr_pll | wr_flags | wr_mask) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (BREADY_I)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // read channel
  assign ar_hs = ARVALID_I & arready_q;

  always_comb
  begin
    rd_mux  = '0;
    rd_resp = RESP_OKAY;
    case (ARADDR_I)
      OFS_PLL:   rd_mux = pll_q & PLL_RW_MASK;
      OFS_FLAGS: rd_mux = {{(32-FLAG_W){1'b0}}, flags_q};
      OFS_MASK:  rd_mux = {{(32-MASK_W){1'b0}}, mask_q};
      default:   rd_resp = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end
    else
    begin
      if (ar_hs)
      begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_mux;
        rresp_q   <= rd_resp;
      end
      else if (rvalid_q & RREADY_I)
      begin
        arready_q <= 1'b1;
        rvalid_q  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // pll setup: only the power-on reset touches it, system reset is ignored here
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      pll_q <= PLL_RST;
    end
    else if (wr_pll)
    begin
      pll_q <= merge(pll_q, wdata_q, wstrb_q) & PLL_RW_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // mask register, one means masked
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      mask_q <= MASK_RST;
    end
    else if (wr_mask & wstrb_q[0])
    begin
      mask_q <= wdata_q[MASK_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // event detection
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      lock_prev_q    <= 1'b0;
      sys_rst_prev_q <= 1'b0;
    end
    else
    begin
      lock_prev_q    <= PLL_LOCK_I;
      sys_rst_prev_q <= SYS_RESET_I;
    end
  end

  // cause inputs are sampled in the cycle the system reset releases
  assign leave_rst          = sys_rst_prev_q & ~SYS_RESET_I;
  assign set_vec[FLG_LOCK]  = pll_q[PLL_EN_BIT] & PLL_LOCK_I & ~lock_prev_q;
  assign set_vec[FLG_LOST]  = pll_q[PLL_EN_BIT] & ~PLL_LOCK_I & lock_prev_q;
  assign set_vec[FLG_WDG]   = leave_rst & WDG_CAUSE_I;
  assign set_vec[FLG_LVD]   = leave_rst & LVD_CAUSE_I;
  assign set_vec[FLG_ACK]   = CACHE_ACK_I;
  assign set_vec[FLG_ERR]   = MEM_WR_ERR_I;
  assign clr_vec            = (wr_flags & wstrb_q[0]) ? wdata_q[FLAG_W-1:0] : '0;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // sticky flags: a set in the clearing cycle wins
  for (genvar k = 0; k < FLAG_W; k++)
  begin : g_flag
    assign flags_d[k] = set_vec[k] | (flags_q[k] & ~clr_vec[k]);
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      flags_q <= FLAG_RST;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // interrupt: watchdog flag has no mask and never interrupts
  assign pend[MSK_LOCK] = flags_q[FLG_LOCK] & ~mask_q[MSK_LOCK];
  assign pend[MSK_LOST] = flags_q[FLG_LOST] & ~mask_q[MSK_LOST];
  assign pend[MSK_ACK]  = flags_q[FLG_ACK]  & ~mask_q[MSK_ACK];
  assign pend[MSK_ERR]  = flags_q[FLG_ERR]  & ~mask_q[MSK_ERR];
  assign pend[MSK_LVD]  = flags_q[FLG_LVD]  & ~mask_q[MSK_LVD];

  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign AWREADY_O      = awready_q;
  assign WREADY_O       = wready_q;
  assign BVALID_O       = bvalid_q;
  assign BRESP_O        = bresp_q;
  assign ARREADY_O      = arready_q;
  assign RVALID_O       = rvalid_q;
  assign RDATA_O        = rdata_q;
  assign RRESP_O        = rresp_q;
  assign PLL_EN_O       = pll_q[PLL_EN_BIT];
  assign PLL_POST_DIV_O = pll_q[POST_MSB:POST_LSB];
  assign PLL_FB_DIV_O   = pll_q[FB_MSB:FB_LSB];
  assign PLL_PRE_DIV_O  = pll_q[PRE_MSB:PRE_LSB];
  assign IRQ_O          = irq_q;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence s_pll_full_write;
    wr_pll && (wstrb_q == 4'hf);
  endsequence

  sequence s_flag_read;
    ar_hs && (ARADDR_I == OFS_FLAGS);
  endsequence

  sequence s_pll_read;
    ar_hs && (ARADDR_I == OFS_PLL);
  endsequence

  a_pll_rsvd_zero: assert property (s_pll_read |=> RVALID_O && (RDATA_O[31:20] == 12'h000))
    else $error("pll setup reserved bits not zero");
  a_flag_rsvd_zero: assert property (s_flag_read |=> RVALID_O && (RDATA_O[31:6] == 26'h0))
    else $error("flag reserved bits not zero");
  a_pll_en_write: assert property (s_pll_full_write |=> PLL_EN_O == $past(wdata_q[19]))
    else $error("pll enable not taken from write");
  a_post_div_write: assert property (s_pll_full_write |=> PLL_POST_DIV_O == $past(wdata_q[18:16]))
    else $error("post divide not taken from write");
  a_fb_pre_write: assert property (s_pll_full_write |=>
                                   {PLL_FB_DIV_O, PLL_PRE_DIV_O} == $past(wdata_q[15:0]))
    else $error("feedback or pre divide not taken from write");
  a_pll_holds: assert property (!wr_pll |=> $stable(pll_q))
    else $error("pll setup changed without a write");
  a_err_sets: assert property (MEM_WR_ERR_I |=> flags_q[FLG_ERR])
    else $error("write error flag not set");
  a_ack_sets: assert property (CACHE_ACK_I |=> flags_q[FLG_ACK])
    else $error("cache ack flag not set");
  a_lvd_leave: assert property (leave_rst && LVD_CAUSE_I |=> flags_q[FLG_LVD])
    else $error("low voltage flag not set on reset release");
  a_wdg_leave: assert property (leave_rst && WDG_CAUSE_I |=> flags_q[FLG_WDG])
    else $error("watchdog flag not set on reset release");
  a_lock_edges: assert property (pll_q[19] && $rose(PLL_LOCK_I) |=> flags_q[FLG_LOCK])
    else $error("lock flag not set on lock");
  a_lost_edges: assert property (pll_q[19] && $fell(PLL_LOCK_I) |=> flags_q[FLG_LOST])
    else $error("lock lost flag not set on loss");
  a_no_edge_off: assert property (!pll_q[19] && $rose(PLL_LOCK_I) && !flags_q[FLG_LOCK] |=>
                                  !flags_q[FLG_LOCK])
    else $error("lock flag set while pll disabled");
  a_irq_follows: assert property (IRQ_O == $past(|pend))
    else $error("interrupt not raised for pending flag");
  a_w1c_clears: assert property (wr_flags && wstrb_q[0] && wdata_q[0] && !set_vec[0] |=>
                                 !flags_q[0])
    else $error("write one did not clear flag");
  a_w0_keeps: assert property (wr_flags && !wdata_q[5] && flags_q[5] |=> flags_q[5])
    else $error("write zero cleared flag");
  a_mask_masks: assert property (mask_q[MSK_ERR] && mask_q[MSK_LOCK] && mask_q[MSK_LOST] &&
                                 mask_q[MSK_ACK] && mask_q[MSK_LVD] |=> !IRQ_O)
    else $error("interrupt raised while all masked");
  a_write_resp: assert property (do_write |=> BVALID_O [*1] ##0 AWREADY_O)
    else $error("write response missing");

endmodule : pcr_pll_status

// ### tb/pcr_pll_model.sv
// behavioural pll macro facing the block: locks a while after enable
`timescale 1ns/1ps
module pcr_pll_model #(
  parameter int LOCK_CYC = 8    // enabled cycles counted; lock follows one cycle later
) (
  input  wire logic clk_i,      // reference clock
  input  wire logic rst_b_i,    // power-on reset, active low
  input  wire logic en_i,       // pll enable from the block
  input  wire logic drop_i,     // bench command: lose lock
  output logic      lock_o      // lock indication to the block
);
  int cnt_q;

  ////////////////////////////////////////////////////////////////////////////////
  // lock settles only after a run of enabled cycles, like a real loop filter
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_q  <= 0;
      lock_o <= 1'b0;
    end
    else
    begin
      cnt_q  <= (en_i && !drop_i) ? ((cnt_q < LOCK_CYC) ? cnt_q + 1 : cnt_q) : 0;
      lock_o <= en_i && !drop_i && (cnt_q >= LOCK_CYC);
    end
  end
endmodule : pcr_pll_model

// ### tb/testbench.sv
// self-checking bench for the pll setup and event flag block
`timescale 1ns/1ps
module testbench;
  import pcr_pkg::*;
  logic REF_CLK_I = 1'b0, RST_B_I = 1'b0, SYS_RESET_I = 1'b0, LVD_CAUSE_I = 1'b0;
  logic WDG_CAUSE_I = 1'b0, PLL_LOCK_I, MEM_WR_ERR_I = 1'b0, CACHE_ACK_I = 1'b0;
  logic [7:0] AWADDR_I = 8'h00, ARADDR_I = 8'h00;
  logic [31:0] WDATA_I = 32'h0, RDATA_O;
  logic [3:0] WSTRB_I = 4'h0;
  logic AWVALID_I = 1'b0, WVALID_I = 1'b0, BREADY_I = 1'b0, ARVALID_I = 1'b0;
  logic RREADY_I = 1'b0, AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
  logic [1:0] BRESP_O, RRESP_O;
  logic PLL_EN_O, IRQ_O, drop = 1'b0;
  logic [2:0] PLL_POST_DIV_O;
  logic [7:0] PLL_FB_DIV_O, PLL_PRE_DIV_O;
  int mismatches = 0, checked = 0;

  always #2.5 REF_CLK_I = ~REF_CLK_I;

  pcr_pll_status dut (.REF_CLK_I(REF_CLK_I), .RST_B_I(RST_B_I), .SYS_RESET_I(SYS_RESET_I),
    .LVD_CAUSE_I(LVD_CAUSE_I), .WDG_CAUSE_I(WDG_CAUSE_I), .PLL_LOCK_I(PLL_LOCK_I),
    .MEM_WR_ERR_I(MEM_WR_ERR_I), .CACHE_ACK_I(CACHE_ACK_I), .AWADDR_I(AWADDR_I),
    .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WDATA_I(WDATA_I), .WSTRB_I(WSTRB_I),
    .WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BRESP_O(BRESP_O), .BVALID_O(BVALID_O),
    .BREADY_I(BREADY_I), .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O),
    .RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
    .PLL_EN_O(PLL_EN_O), .PLL_POST_DIV_O(PLL_POST_DIV_O), .PLL_FB_DIV_O(PLL_FB_DIV_O),
    .PLL_PRE_DIV_O(PLL_PRE_DIV_O), .IRQ_O(IRQ_O));

  pcr_pll_model #(.LOCK_CYC(8)) pll (.clk_i(REF_CLK_I), .rst_b_i(RST_B_I), .en_i(PLL_EN_O),
    .drop_i(drop), .lock_o(PLL_LOCK_I));

  ////////////////////////////////////////////////////////////////////////////////
  task close_out;
  begin
    if (mismatches == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask : close_out

  task chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask : chk

  task tick(input int n);
  begin
    repeat (n) @(posedge REF_CLK_I);
  end
  endtask : tick

  // write and wait for the response; a hung bus ends the run
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    bit done;
  begin
    done = 1'b0;
    @(posedge REF_CLK_I);
    AWADDR_I <= a; AWVALID_I <= 1'b1; WDATA_I <= d; WSTRB_I <= 4'hf;
    WVALID_I <= 1'b1; BREADY_I <= 1'b1;
    for (n = 0; n < 40 && !done; n++)
    begin
      @(posedge REF_CLK_I);
      if (AWVALID_I && AWREADY_O) AWVALID_I <= 1'b0;
      if (WVALID_I && WREADY_O) WVALID_I <= 1'b0;
      if (BVALID_O)
      begin
        BREADY_I <= 1'b0;
        done = 1'b1;
        chk({30'h0, BRESP_O}, {30'h0, RESP_OKAY});
      end
    end
    if (!done)
    begin
      mismatches++;
      close_out();
    end
  end
  endtask : wr

  // read one word and compare data and response
  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rsp);
    int n;
    bit done;
  begin
    done = 1'b0;
    @(posedge REF_CLK_I);
    ARADDR_I <= a; ARVALID_I <= 1'b1; RREADY_I <= 1'b1;
    for (n = 0; n < 40 && !done; n++)
    begin
      @(posedge REF_CLK_I);
      if (ARVALID_I && ARREADY_O) ARVALID_I <= 1'b0;
      if (RVALID_O)
      begin
        RREADY_I <= 1'b0;
        done = 1'b1;
        chk(RDATA_O, exp);
        chk({30'h0, RRESP_O}, {30'h0, rsp});
      end
    end
    if (!done)
    begin
      mismatches++;
      close_out();
    end
  end
  endtask : rd

  // system reset with a chosen cause; registers must not reset
  task sysrst(input logic lvd, input logic wdg);
  begin
    @(posedge REF_CLK_I);
    SYS_RESET_I <= 1'b1; LVD_CAUSE_I <= lvd; WDG_CAUSE_I <= wdg;
    tick(3);
    SYS_RESET_I <= 1'b0;
    tick(2);
    LVD_CAUSE_I <= 1'b0; WDG_CAUSE_I <= 1'b0;
    tick(1);
  end
  endtask : sysrst

  // one-cycle event pulse, then let flag and irq settle
  task evt(input logic err);
  begin
    @(posedge REF_CLK_I);
    MEM_WR_ERR_I <= err; CACHE_ACK_I <= !err;
    @(posedge REF_CLK_I);
    MEM_WR_ERR_I <= 1'b0; CACHE_ACK_I <= 1'b0;
    tick(3);
  end
  endtask : evt

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    tick(2);
    RST_B_I <= 1'b1;
    tick(1);
    chk({31'h0, PLL_EN_O}, 32'h0);
    chk({29'h0, PLL_POST_DIV_O}, 32'h3);
    chk({24'h0, PLL_FB_DIV_O}, 32'hc0);
    chk({24'h0, PLL_PRE_DIV_O}, 32'h19);
    rd(OFS_PLL, 32'h0003c019, RESP_OKAY);
    rd(OFS_FLAGS, 32'h00000008, RESP_OKAY);
    rd(OFS_MASK, 32'h0000001f, RESP_OKAY);
    rd(8'h0c, 32'h0, RESP_SLVERR);
    wr(OFS_FLAGS, 32'h0);
    rd(OFS_FLAGS, 32'h00000008, RESP_OKAY);
    wr(OFS_FLAGS, 32'hffffffff);
    rd(OFS_FLAGS, 32'h0, RESP_OKAY);
    // all ones also enables the pll; reserved bits must stay zero
    wr(OFS_PLL, 32'hffffffff);
    rd(OFS_PLL, 32'h000fffff, RESP_OKAY);
    chk({PLL_EN_O, PLL_POST_DIV_O, PLL_FB_DIV_O, PLL_PRE_DIV_O}, 32'hfffff);
    tick(20);
    rd(OFS_FLAGS, 32'h1, RESP_OKAY);
    drop <= 1'b1;
    tick(4);
    rd(OFS_FLAGS, 32'h3, RESP_OKAY);
    drop <= 1'b0;
    wr(OFS_PLL, 32'h00051234);
    chk({PLL_EN_O, PLL_POST_DIV_O, PLL_FB_DIV_O, PLL_PRE_DIV_O}, 32'h51234);
    wr(OFS_FLAGS, 32'h3f);
    tick(20);
    rd(OFS_FLAGS, 32'h0, RESP_OKAY);
    sysrst(1'b1, 1'b0);
    rd(OFS_FLAGS, 32'h8, RESP_OKAY);
    rd(OFS_PLL, 32'h00051234, RESP_OKAY);
    wr(OFS_FLAGS, 32'h4);
    sysrst(1'b0, 1'b1);
    rd(OFS_FLAGS, 32'hc, RESP_OKAY);
    rd(OFS_MASK, 32'h1f, RESP_OKAY);
    wr(OFS_FLAGS, 32'hc);
    evt(1'b1);
    evt(1'b0);
    rd(OFS_FLAGS, 32'h30, RESP_OKAY);
    chk({31'h0, IRQ_O}, 32'h0);
    wr(OFS_MASK, 32'h17);
    tick(2);
    chk({31'h0, IRQ_O}, 32'h1);
    wr(OFS_FLAGS, 32'h20);
    tick(2);
    chk({31'h0, IRQ_O}, 32'h0);
    wr(OFS_MASK, 32'h1b);
    tick(2);
    chk({31'h0, IRQ_O}, 32'h1);
    wr(OFS_FLAGS, 32'h10);
    tick(2);
    chk({31'h0, IRQ_O}, 32'h0);
    // low-voltage flag interrupts only through its own mask bit
    sysrst(1'b1, 1'b0);
    chk({31'h0, IRQ_O}, 32'h0);
    wr(OFS_MASK, 32'h0f);
    tick(2);
    chk({31'h0, IRQ_O}, 32'h1);
    wr(OFS_MASK, 32'h1e);
    tick(2);
    chk({31'h0, IRQ_O}, 32'h0);
    wr(OFS_PLL, 32'h0008c019);
    tick(20);
    chk({31'h0, IRQ_O}, 32'h1);
    close_out();
  end
endmodule : testbench
